// ---- core/dpsc_pkg.sv ----
package dpsc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DW      = 40;
    localparam int WW      = 32;
    localparam int IW      = 48;
    localparam int NREG    = 16;
    localparam int NDAG    = 8;
    localparam int AW      = 32;
    localparam int PCW     = 14;
    localparam int CIW     = 4;
    localparam int MODE_W  = 3;
    localparam int PAD_W   = DW - WW;
    // ------------------------------------------------------------
    // instruction fields (lsb positions)
    // ------------------------------------------------------------
    localparam int F_OP    = 45;
    localparam int F_AOP   = 43;
    localparam int F_FMT   = 41;
    localparam int F_RD    = 37;
    localparam int F_RA    = 33;
    localparam int F_RB    = 29;
    localparam int F_RM    = 25;
    localparam int F_RX    = 21;
    localparam int F_RY    = 17;
    localparam int F_COND  = 15;
    localparam int F_BR    = 14;
    localparam int F_TGT   = 0;
    localparam int F_DIR   = 16;
    localparam int F_DMR   = 12;
    localparam int F_PMR   = 8;
    localparam int F_DMI   = 5;
    localparam int F_PMI   = 2;
    localparam int F_C2    = 0;
    localparam int F_DGEN  = 44;
    localparam int F_DIDX  = 41;
    localparam int F_DFLD  = 39;
    localparam int F_VAL   = 0;
    localparam int F_SHAMT = 0;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [2:0] OP_NOP   = 3'h0;
    localparam logic [2:0] OP_COMP  = 3'h1;
    localparam logic [2:0] OP_CMEM  = 3'h2;
    localparam logic [2:0] OP_MODE  = 3'h3;
    localparam logic [2:0] OP_DAG   = 3'h4;
    localparam logic [2:0] OP_SHIFT = 3'h5;
    localparam logic [1:0] ALU_ADD    = 2'h0;
    localparam logic [1:0] ALU_SUB    = 2'h1;
    localparam logic [1:0] ALU_ADDSUB = 2'h2;
    localparam logic [1:0] ALU_AND    = 2'h3;
    localparam logic [1:0] FMT_FIX = 2'h0;
    localparam logic [1:0] FMT_F32 = 2'h1;
    localparam logic [1:0] FMT_F40 = 2'h2;
    localparam logic [1:0] COND_ALW = 2'h0;
    localparam logic [1:0] COND_EQ  = 2'h1;
    localparam logic [1:0] COND_LT  = 2'h2;
    localparam logic [1:0] COND_NE  = 2'h3;
    localparam logic [1:0] DF_IDX  = 2'h0;
    localparam logic [1:0] DF_MOD  = 2'h1;
    localparam logic [1:0] DF_LEN  = 2'h2;
    localparam logic [1:0] DF_BASE = 2'h3;
    // ------------------------------------------------------------
    // primary mode register bits and reset values
    // ------------------------------------------------------------
    localparam int MODE_PEY_BIT    = 0;
    localparam int MODE_BANK_BIT   = 1;
    localparam int MODE_DAGSEC_BIT = 2;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
    localparam logic [PCW-1:0]    PC_RST   = 14'h0000;
    localparam logic [IW-1:0]     INSTR_NOP = 48'h000000000000;
    localparam int FE_EXP_BIAS = 127;

    typedef enum logic [1:0] {
        FS_RUN    = 2'b00,
        FS_REFILL = 2'b01
    } dpsc_fetch_e;
endpackage

// ---- core/dpsc_core.sv ----
// Operation
// - first element always on, second by bit
// - both elements run same instruction, own data
// - lockstep mode moves two values per access
// - alu, multiplier parallel, shifter own instruction, one cycle
// - multifunction: alu and multiply together
// - fixed, single and extended float formats
// - sixteen primary, sixteen secondary registers each
// - both elements use same index range
// - data bus data only; program bus both
// - four operands plus cached instruction per cycle
// - four word transfers per cycle total
// - cache only fetches colliding with program data
// - thirty-two circular buffer register sets
// - pointer wraps automatically past buffer end
// - no alignment restriction on base, length
// - fixed 48-bit word, several operations
// - conditional multiply, add, subtract with branch
module dpsc_core
    import dpsc_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    output logic [dpsc_pkg::AW-1:0]       pm_addr,
    output logic                          pm_fetch,
    output logic                          pm_rd,
    output logic                          pm_wr,
    output logic                          pm_lane1_en,
    output logic [dpsc_pkg::WW-1:0]       pm_wdata0,
    output logic [dpsc_pkg::WW-1:0]       pm_wdata1,
    input  wire logic [dpsc_pkg::IW-1:0]  pm_rdata0,
    input  wire logic [dpsc_pkg::WW-1:0]  pm_rdata1,
    output logic [dpsc_pkg::AW-1:0]       dm_addr,
    output logic                          dm_rd,
    output logic                          dm_wr,
    output logic                          dm_lane1_en,
    output logic [dpsc_pkg::WW-1:0]       dm_wdata0,
    output logic [dpsc_pkg::WW-1:0]       dm_wdata1,
    input  wire logic [dpsc_pkg::WW-1:0]  dm_rdata0,
    input  wire logic [dpsc_pkg::WW-1:0]  dm_rdata1,
    output logic                          dual_mode_on,
    output logic [dpsc_pkg::PCW-1:0]      pc_out
);
    import dpsc_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic cond_ok(input logic [1:0] c,
                                     input logic z, input logic n);
        case (c)
            COND_ALW: cond_ok = 1'b1;
            COND_EQ:  cond_ok = z;
            COND_LT:  cond_ok = n;
            COND_NE:  cond_ok = !z;
            default:  cond_ok = 1'b1;
        endcase
    endfunction

    // truncating multiply, no denormals; float32 is the top 32 bits
    function automatic logic [DW-1:0] fmul(input logic [DW-1:0] a,
                                           input logic [DW-1:0] b);
        logic [63:0] p;
        logic [9:0]  e;
        logic [30:0] m;
        p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
        e = {2'b00, a[38:31]} + {2'b00, b[38:31]} - 10'(FE_EXP_BIAS);
        if (p[63]) begin
            m = p[62:32];
            e = e + 10'h001;
        end else begin
            m = p[61:31];
        end
        if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e[9]
            || e == 10'h000) begin
            fmul = {a[39] ^ b[39], 39'h0};
        end else if (e[8]) begin
            fmul = {a[39] ^ b[39], 8'hff, 31'h0};
        end else begin
            fmul = {a[39] ^ b[39], e[7:0], m};
        end
    endfunction

    function automatic logic [AW-1:0] circ_next(input logic [AW-1:0] i,
            input logic [AW-1:0] m, input logic [AW-1:0] l,
            input logic [AW-1:0] b);
        logic [AW-1:0] n;
        n = i + m;
        circ_next = n;
        if (l != 32'h0) begin
            if (!m[AW-1] && (n - b) >= l) begin
                circ_next = n - l;
            end else if (m[AW-1] && n < b) begin
                circ_next = n + l;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [IW-1:0]      ir_ff, nxt_ir;
    logic [PCW-1:0]     pc_ff, nxt_pc;
    logic [MODE_W-1:0]  mode_ff, nxt_mode;
    dpsc_fetch_e        fs_ff, nxt_fs;
    logic [2:0]         op;
    logic               bank;
    logic               dsec;
    logic               mem_op;
    logic               br_take;
    logic               flag_z [2];
    logic               flag_n [2];
    logic [WW-1:0]      st_dm [2];
    logic [WW-1:0]      st_pm [2];
    logic [WW-1:0]      ld_dm [2];
    logic [WW-1:0]      ld_pm [2];

    // 48-bit word packs compute, memory and branch fields
    assign op     = ir_ff[F_OP +: 3];
    assign bank   = mode_ff[MODE_BANK_BIT];
    assign dsec   = mode_ff[MODE_DAGSEC_BIT];
    assign mem_op = (op == OP_CMEM);
    assign br_take = (op == OP_COMP) && ir_ff[F_BR]
                   && cond_ok(ir_ff[F_COND +: 2], flag_z[0],
                              flag_n[0]);
    assign dual_mode_on = mode_ff[MODE_PEY_BIT];
    assign pc_out = pc_ff;
    assign ld_dm[0] = dm_rdata0;
    assign ld_dm[1] = dm_rdata1;
    assign ld_pm[0] = pm_rdata0[WW-1:0];
    assign ld_pm[1] = pm_rdata1;

    // ------------------------------------------------------------
    // address generators
    // ------------------------------------------------------------
    // set index = {generator, secondary}; 4 sets x 8 = 32 buffers
    logic [AW-1:0] dag_ff  [4][4][NDAG];
    logic [AW-1:0] nxt_dag [4][4][NDAG];
    logic [1:0]    dm_set, pm_set;
    logic [2:0]    dmi, pmi;

    assign dm_set = {1'b0, dsec};
    assign pm_set = {1'b1, dsec};
    assign dmi    = ir_ff[F_DMI +: 3];
    assign pmi    = ir_ff[F_PMI +: 3];

    always_comb begin
        nxt_dag = dag_ff;
        if (op == OP_DAG) begin
            nxt_dag[{ir_ff[F_DGEN], dsec}][ir_ff[F_DFLD +: 2]]
                   [ir_ff[F_DIDX +: 3]] = ir_ff[F_VAL +: AW];
        end
        if (mem_op) begin
            nxt_dag[dm_set][DF_IDX][dmi] = circ_next(
                dag_ff[dm_set][DF_IDX][dmi], dag_ff[dm_set][DF_MOD][dmi],
                dag_ff[dm_set][DF_LEN][dmi],
                dag_ff[dm_set][DF_BASE][dmi]);
            nxt_dag[pm_set][DF_IDX][pmi] = circ_next(
                dag_ff[pm_set][DF_IDX][pmi], dag_ff[pm_set][DF_MOD][pmi],
                dag_ff[pm_set][DF_LEN][pmi],
                dag_ff[pm_set][DF_BASE][pmi]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < 4; s++) begin
                for (int f = 0; f < 4; f++) begin
                    for (int k = 0; k < NDAG; k++) begin
                        dag_ff[s][f][k] <= 32'h0;
                    end
                end
            end
        end else begin
            dag_ff <= nxt_dag;
        end
    end

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    // post-modify: the access uses the pointer before the step
    always_comb begin
        dm_addr     = dag_ff[dm_set][DF_IDX][dmi];
        dm_rd       = mem_op && !ir_ff[F_DIR];
        dm_wr       = mem_op && ir_ff[F_DIR];
        dm_lane1_en = mem_op && mode_ff[MODE_PEY_BIT];
        dm_wdata0   = st_dm[0];
        dm_wdata1   = dm_lane1_en ? st_dm[1] : 32'h0;
        pm_rd       = mem_op && !ir_ff[F_DIR];
        pm_wr       = mem_op && ir_ff[F_DIR];
        pm_lane1_en = mem_op && mode_ff[MODE_PEY_BIT];
        pm_wdata0   = st_pm[0];
        pm_wdata1   = pm_lane1_en ? st_pm[1] : 32'h0;
        pm_fetch    = !mem_op;
        if (mem_op) begin
            pm_addr = dag_ff[pm_set][DF_IDX][pmi];
        end else begin
            pm_addr = {18'h00000, pc_ff};
        end
    end

    // ------------------------------------------------------------
    // fetch and selective cache
    // ------------------------------------------------------------
    logic [IW-1:0]      c_data_ff  [1 << CIW];
    logic [PCW-CIW-1:0] c_tag_ff   [1 << CIW];
    logic               c_val_ff   [1 << CIW];
    logic [IW-1:0]      nxt_c_data [1 << CIW];
    logic [PCW-CIW-1:0] nxt_c_tag  [1 << CIW];
    logic               nxt_c_val  [1 << CIW];
    logic [CIW-1:0]     cidx;
    logic               c_hit;

    assign cidx  = pc_ff[CIW-1:0];
    assign c_hit = c_val_ff[cidx] && (c_tag_ff[cidx] == pc_ff[PCW-1:CIW]);

    always_comb begin
        nxt_c_data = c_data_ff;
        nxt_c_tag  = c_tag_ff;
        nxt_c_val  = c_val_ff;
        nxt_pc     = pc_ff;
        nxt_ir     = INSTR_NOP;
        nxt_fs     = fs_ff;
        case (fs_ff)
            FS_RUN: begin
                if (br_take) begin
                    nxt_pc = ir_ff[F_TGT +: PCW];
                end else if (mem_op && c_hit) begin
                    nxt_ir = c_data_ff[cidx];
                    nxt_pc = pc_ff + 14'h0001;
                end else if (mem_op) begin
                    nxt_fs = FS_REFILL;
                end else begin
                    nxt_ir = pm_rdata0;
                    nxt_pc = pc_ff + 14'h0001;
                end
            end
            FS_REFILL: begin
                // only a fetch that lost the bus is kept
                nxt_c_data[cidx] = pm_rdata0;
                nxt_c_tag[cidx]  = pc_ff[PCW-1:CIW];
                nxt_c_val[cidx]  = 1'b1;
                nxt_ir = pm_rdata0;
                nxt_pc = pc_ff + 14'h0001;
                nxt_fs = FS_RUN;
            end
            default: begin
                nxt_fs = FS_RUN;
            end
        endcase
        nxt_mode = mode_ff;
        if (op == OP_MODE) begin
            nxt_mode = ir_ff[MODE_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff   <= PC_RST;
            ir_ff   <= INSTR_NOP;
            fs_ff   <= FS_RUN;
            mode_ff <= MODE_RST;
            for (int k = 0; k < (1 << CIW); k++) begin
                c_data_ff[k] <= INSTR_NOP;
                c_tag_ff[k]  <= '0;
                c_val_ff[k]  <= 1'b0;
            end
        end else begin
            pc_ff     <= nxt_pc;
            ir_ff     <= nxt_ir;
            fs_ff     <= nxt_fs;
            mode_ff   <= nxt_mode;
            c_data_ff <= nxt_c_data;
            c_tag_ff  <= nxt_c_tag;
            c_val_ff  <= nxt_c_val;
        end
    end

    // ------------------------------------------------------------
    // processing elements
    // ------------------------------------------------------------
    // 32-bit words live in bits 39:8; float32 shares the 40-bit layout
    for (genvar p = 0; p < 2; p++) begin : g_pe
        logic [DW-1:0] rf_ff  [2][NREG];
        logic [DW-1:0] nxt_rf [2][NREG];
        logic          z_ff, n_ff, nxt_z, nxt_n;
        logic          active;
        logic          en;
        logic [WW-1:0] a, b, sum, dif, alu;
        logic [63:0]   ip;
        logic [DW-1:0] mul;
        logic [7:0]    amt, namt;

        // the second element stays frozen in single element mode
        assign active = (p == 0) || mode_ff[MODE_PEY_BIT];
        assign st_dm[p] = rf_ff[bank][ir_ff[F_DMR +: 4]][DW-1:PAD_W];
        assign st_pm[p] = rf_ff[bank][ir_ff[F_PMR +: 4]][DW-1:PAD_W];
        assign flag_z[p] = z_ff;
        assign flag_n[p] = n_ff;

        always_comb begin
            nxt_rf = rf_ff;
            nxt_z  = z_ff;
            nxt_n  = n_ff;
            // same index fields select R or S registers per element
            a   = rf_ff[bank][ir_ff[F_RA +: 4]][DW-1:PAD_W];
            b   = rf_ff[bank][ir_ff[F_RB +: 4]][DW-1:PAD_W];
            sum = a + b;
            dif = a - b;
            case (ir_ff[F_AOP +: 2])
                ALU_ADD:    alu = sum;
                ALU_SUB:    alu = dif;
                ALU_ADDSUB: alu = sum;
                ALU_AND:    alu = a & b;
                default:    alu = sum;
            endcase
            ip = $signed(rf_ff[bank][ir_ff[F_RX +: 4]][DW-1:PAD_W])
               * $signed(rf_ff[bank][ir_ff[F_RY +: 4]][DW-1:PAD_W]);
            mul = fmul(rf_ff[bank][ir_ff[F_RX +: 4]],
                       rf_ff[bank][ir_ff[F_RY +: 4]]);
            case (ir_ff[F_FMT +: 2])
                FMT_FIX: mul = {ip[WW-1:0], 8'h00};
                FMT_F32: mul = {mul[DW-1:PAD_W], 8'h00};
                FMT_F40: mul = mul;
                default: mul = {ip[WW-1:0], 8'h00};
            endcase
            en = active && ((op == OP_COMP
                  && cond_ok(ir_ff[F_COND +: 2], z_ff, n_ff))
                 || (mem_op
                  && cond_ok(ir_ff[F_C2 +: 2], z_ff, n_ff)));
            if (en) begin
                nxt_rf[bank][ir_ff[F_RD +: 4]] = {alu, 8'h00};
                if (ir_ff[F_AOP +: 2] == ALU_ADDSUB) begin
                    nxt_rf[bank][ir_ff[F_RD +: 4] ^ 4'h8] =
                        {dif, 8'h00};
                end
                nxt_rf[bank][ir_ff[F_RM +: 4]] = mul;
                nxt_z = (alu == 32'h0);
                nxt_n = alu[WW-1];
            end
            amt  = ir_ff[F_SHAMT +: 8];
            namt = 8'h00 - amt;
            if (active && op == OP_SHIFT) begin
                nxt_rf[bank][ir_ff[F_RD +: 4]] = amt[7]
                    ? {a >> namt, 8'h00}
                    : {a << amt, 8'h00};
            end
            if (active && mem_op && !ir_ff[F_DIR]) begin
                nxt_rf[bank][ir_ff[F_DMR +: 4]] =
                    {ld_dm[p], 8'h00};
                nxt_rf[bank][ir_ff[F_PMR +: 4]] =
                    {ld_pm[p], 8'h00};
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                z_ff <= 1'b0;
                n_ff <= 1'b0;
                for (int s = 0; s < 2; s++) begin
                    for (int k = 0; k < NREG; k++) begin
                        rf_ff[s][k] <= 40'h0;
                    end
                end
            end else begin
                z_ff  <= nxt_z;
                n_ff  <= nxt_n;
                rf_ff <= nxt_rf;
            end
        end
    end

endmodule // dpsc_core

// ---- dv/dpsc_core_properties.sv ----
// ----------------------------------------
// bus relations at the core ports
// ----------------------------------------
module dpsc_core_properties
    import dpsc_pkg::*;
(
    input wire logic                       mclk,
    input wire logic                       rst_n,
    input wire logic [dpsc_pkg::AW-1:0]    pm_addr,
    input wire logic                       pm_fetch,
    input wire logic                       pm_rd,
    input wire logic                       pm_wr,
    input wire logic                       pm_lane1_en,
    input wire logic [dpsc_pkg::WW-1:0]    pm_wdata1,
    input wire logic                       dm_rd,
    input wire logic                       dm_wr,
    input wire logic                       dm_lane1_en,
    input wire logic [dpsc_pkg::WW-1:0]    dm_wdata1,
    input wire logic                       dual_mode_on,
    input wire logic [dpsc_pkg::PCW-1:0]   pc_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_fetch_excl: assert property (
        (pm_rd || pm_wr) |-> !pm_fetch) else $error("pm data cycle fetched");
    chk_fetch_addr: assert property (
        pm_fetch |-> pm_addr == AW'(pc_out)) else $error("fetch addr not pc");
    chk_pm_lane: assert property (
        (pm_rd || pm_wr) |-> pm_lane1_en == dual_mode_on)
        else $error("pm lane enable wrong");
    chk_dm_lane: assert property (
        (dm_rd || dm_wr) |-> dm_lane1_en == dual_mode_on)
        else $error("dm lane enable wrong");
    chk_idle_lane: assert property (
        !dual_mode_on |-> pm_wdata1 == '0 && dm_wdata1 == '0)
        else $error("idle lane drives data");
    chk_read_pair: assert property (
        (dm_rd || pm_rd) |-> dm_rd && pm_rd) else $error("reads not paired");
    chk_write_pair: assert property (
        (dm_wr || pm_wr) |-> dm_wr && pm_wr) else $error("writes not paired");
    chk_reset_state: assert property (
        !$past(rst_n) |-> $past(pc_out) == '0 && !$past(dual_mode_on)
        && $past(pm_fetch)) else $error("state after reset wrong");
    chk_refill_pc: assert property (
        (pm_rd || pm_wr) ##1 pm_fetch |-> pc_out == $past(pc_out)
        || pc_out == $past(pc_out) + 1'b1) else $error("pc jump after data");

    cov_dual_store: cover property (dm_wr && dual_mode_on);
    cov_single_load: cover property (dm_rd && !dual_mode_on);
    cov_refill: cover property ((pm_rd || pm_wr) ##1 pm_fetch);
endmodule // dpsc_core_properties

bind dpsc_core dpsc_core_properties u_props (.*);

// ---- dv/dpsc_mem_model.sv ----
// ----------------------------------------
// combinational dual-bus memory
// ----------------------------------------
module dpsc_mem_model
    import dpsc_pkg::*;
(
    input wire logic                       mclk,
    input wire logic [dpsc_pkg::AW-1:0]    pm_addr,
    input wire logic                       pm_fetch,
    input wire logic                       pm_rd,
    input wire logic                       pm_wr,
    input wire logic                       pm_lane1_en,
    input wire logic [dpsc_pkg::WW-1:0]    pm_wdata0,
    input wire logic [dpsc_pkg::WW-1:0]    pm_wdata1,
    output logic [dpsc_pkg::IW-1:0]        pm_rdata0,
    output logic [dpsc_pkg::WW-1:0]        pm_rdata1,
    input wire logic [dpsc_pkg::AW-1:0]    dm_addr,
    input wire logic                       dm_rd,
    input wire logic                       dm_wr,
    input wire logic                       dm_lane1_en,
    input wire logic [dpsc_pkg::WW-1:0]    dm_wdata0,
    input wire logic [dpsc_pkg::WW-1:0]    dm_wdata1,
    output logic [dpsc_pkg::WW-1:0]        dm_rdata0,
    output logic [dpsc_pkg::WW-1:0]        dm_rdata1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [IW-1:0] imem [128];
    logic [WW-1:0] pm0 [128];
    logic [WW-1:0] pm1 [128];
    logic [WW-1:0] dm0 [128];
    logic [WW-1:0] dm1 [128];
    logic [6:0]    pa;
    logic [6:0]    da;
    assign pa = pm_addr[6:0];
    assign da = dm_addr[6:0];
    // unread lanes show the inverse
    assign pm_rdata0 = pm_fetch ? imem[pa]
                     : (pm_rd ? {16'h0, pm0[pa]} : ~imem[pa]);
    assign pm_rdata1 = pm_rd ? pm1[pa] : ~pm1[pa];
    assign dm_rdata0 = dm_rd ? dm0[da] : ~dm0[da];
    assign dm_rdata1 = dm_rd ? dm1[da] : ~dm1[da];
    always @(posedge mclk) begin
        if (pm_wr) begin
            pm0[pa] <= pm_wdata0;
            if (pm_lane1_en)
                pm1[pa] <= pm_wdata1;
        end
        if (dm_wr) begin
            dm0[da] <= dm_wdata0;
            if (dm_lane1_en)
                dm1[da] <= dm_wdata1;
        end
    end
endmodule // dpsc_mem_model

// ---- dv/tb_top.sv ----
module tb_top
    import dpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    localparam logic [27:0] CNOP = {ALU_ADD, FMT_FIX, 24'he00f00};
    logic            mclk;
    logic            rst_n;
    logic [AW-1:0]   pm_addr, dm_addr;
    logic            pm_fetch, pm_rd, pm_wr, pm_lane1_en;
    logic            dm_rd, dm_wr, dm_lane1_en, dual_mode_on;
    logic [WW-1:0]   pm_wdata0, pm_wdata1, pm_rdata1, dm_wdata0;
    logic [WW-1:0]   dm_wdata1, dm_rdata0, dm_rdata1;
    logic [IW-1:0]   pm_rdata0;
    logic [PCW-1:0]  pc_out;
    int              n_errors = 0;
    int              samples_checked = 0;
    int              cyc = 0;
    logic [IW-1:0]   prog [$];

    dpsc_core uut (.*);
    dpsc_mem_model mem (.*);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [WW-1:0] e,
                       input logic [WW-1:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [27:0] cf(logic [1:0] a, logic [1:0] f,
        int rd, int ra, int rb, int rm, int rx, int ry);
        return {a, f, 4'(rd), 4'(ra), 4'(rb), 4'(rm), 4'(rx), 4'(ry)};
    endfunction
    function automatic logic [IW-1:0] op_mem(logic [27:0] c, logic d,
        int dr, int pr, int d1, int d2);
        return {OP_CMEM, c, d, 4'(dr), 4'(pr), 3'(d1), 3'(d2), COND_ALW};
    endfunction
    function automatic logic [IW-1:0] op_dag(logic g, int ix,
        logic [1:0] fl, logic [31:0] v);
        return {OP_DAG, g, 3'(ix), fl, 7'h0, v};
    endfunction
    function automatic logic [IW-1:0] op_cmp(logic [27:0] c);
        return {OP_COMP, c, COND_ALW, 1'b0, 14'h0};
    endfunction
    function automatic logic [WW-1:0] lane(int l, int a, logic onpm);
        return onpm ? (l ? mem.pm1[a] : mem.pm0[a])
                    : (l ? mem.dm1[a] : mem.dm0[a]);
    endfunction

    // load program, then reset starts it
    task automatic run(input int n);
        for (int i = 0; i < 128; i++)
            mem.imem[i] = (i < prog.size()) ? prog[i] : INSTR_NOP;
        prog.delete();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (n) @(posedge mclk);
    endtask

    task automatic pre();
        prog.push_back(op_dag(1'b0, 0, DF_IDX, 32'h10));
        prog.push_back(op_dag(1'b0, 0, DF_MOD, 32'h1));
        prog.push_back(op_dag(1'b1, 0, DF_IDX, 32'h20));
        prog.push_back(op_dag(1'b1, 0, DF_MOD, 32'h1));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_dual_element_lockstep_mode(input logic m);
        logic [WW-1:0] a, b;
        for (int j = 16; j < 24; j++) begin
            mem.dm0[j] = '0;
            mem.pm0[j+16] = '0;
            mem.dm1[j] = 32'hffff_ffff;
            mem.pm1[j+16] = 32'hffff_ffff;
        end
        mem.dm0[16] = 32'h1234;
        mem.dm1[16] = 32'h777;
        mem.pm0[32] = 32'h100;
        mem.pm1[32] = 32'h11;
        mem.dm0[22] = 32'h4000_0000;
        mem.dm1[22] = 32'h4000_0000;
        mem.pm0[38] = 32'h4040_0000;
        mem.pm1[38] = 32'h4040_0000;
        pre();
        prog.push_back({OP_MODE, 42'h0, 2'h0, m});
        prog.push_back(op_mem(CNOP, 1'b0, 1, 2, 0, 0));
        for (int k = 0; k < 4; k++) begin
            prog.push_back(op_cmp(cf(2'(k), FMT_FIX, 3, 1, 2, 12, 1, 2)));
            prog.push_back(op_mem(CNOP, 1'b1, 3, 11, 0, 0));
        end
        prog.push_back({OP_SHIFT, 4'h0, 4'h5, 4'h1, 25'h0, 8'h04});
        prog.push_back({OP_SHIFT, 4'h0, 4'h6, 4'h1, 25'h0, 8'hfc});
        prog.push_back(op_mem(CNOP, 1'b1, 5, 6, 0, 0));
        prog.push_back(op_mem(CNOP, 1'b0, 7, 8, 0, 0));
        prog.push_back(op_cmp(cf(ALU_ADD, FMT_F32, 13, 0, 0, 9, 7, 8)));
        prog.push_back(op_cmp(cf(ALU_ADD, FMT_F40, 13, 0, 0, 10, 7, 8)));
        prog.push_back(op_mem(CNOP, 1'b1, 9, 10, 0, 0));
        run(100);
        for (int l = 0; l < 2; l++) begin
            a = l ? 32'h777 : 32'h1234;
            b = l ? 32'h11 : 32'h100;
            if (l == 1 && !m) begin
                chk("idle dm lane", 32'hffff_ffff, lane(1, 17, 1'b0));
                chk("idle pm lane", 32'hffff_ffff, lane(1, 35, 1'b1));
            end else begin
                chk("add", a + b, lane(l, 17, 1'b0));
                chk("sub", a - b, lane(l, 18, 1'b0));
                chk("addsub sum", a + b, lane(l, 19, 1'b0));
                chk("addsub diff", a - b, lane(l, 35, 1'b1));
                chk("and", a & b, lane(l, 20, 1'b0));
                chk("shift left", a << 4, lane(l, 21, 1'b0));
                chk("shift right", a >> 4, lane(l, 37, 1'b1));
                chk("mul f32", 32'h40c0_0000, lane(l, 23, 1'b0));
                chk("mul f40", 32'h40c0_0000, lane(l, 39, 1'b1));
            end
        end
        $display("test dual_element_lockstep_mode %0d done", m);
    endtask

    // unaligned base and length
    task automatic test_circ();
        for (int j = 48; j < 56; j++)
            mem.dm0[j] = '0;
        mem.dm0[16] = 32'h11;
        mem.pm0[32] = 32'h22;
        mem.dm0[17] = 32'h33;
        mem.pm0[33] = 32'h44;
        pre();
        prog.push_back(op_dag(1'b0, 1, DF_BASE, 32'h33));
        prog.push_back(op_dag(1'b0, 1, DF_LEN, 32'h3));
        prog.push_back(op_dag(1'b0, 1, DF_IDX, 32'h34));
        prog.push_back(op_dag(1'b0, 1, DF_MOD, 32'h1));
        prog.push_back(op_dag(1'b1, 1, DF_IDX, 32'h40));
        prog.push_back(op_mem(CNOP, 1'b0, 1, 2, 0, 0));
        prog.push_back(op_mem(CNOP, 1'b0, 3, 4, 0, 0));
        for (int r = 1; r < 5; r++)
            prog.push_back(op_mem(CNOP, 1'b1, r, 0, 1, 1));
        run(80);
        chk("wrap slot", 32'h33, mem.dm0[51]);
        chk("rewrap slot", 32'h44, mem.dm0[52]);
        chk("middle slot", 32'h22, mem.dm0[53]);
        chk("past end", 32'h0, mem.dm0[54]);
        chk("below base", 32'h0, mem.dm0[50]);
        $display("test circular buffer done");
    endtask

    initial begin
        rst_n = 1'b0;
        test_dual_element_lockstep_mode(1'b0);
        test_dual_element_lockstep_mode(1'b1);
        test_circ();
        print_verdict();
    end
endmodule // tb_top
